// *** risc_core_defs.svh ***
/*
 * Constants of the small 8-bit core: instruction fields, opcodes, special
 * register addresses, status bit positions, memory sizes and timing.
 * Assumes it is included by bare name; its guard makes repeated inclusion per compile unit harmless.
 */
// How it works
// - every instruction is one 14-bit word fetched whole in one instruction cycle
// - next word is fetched while the current word executes
// - every instruction takes one instruction cycle; branches cost one more
// - program memory is internal, 512, 1K or 2K words of 14 bits
// - program fetch and data access use separate memories and buses at once
// - special registers, program counter too, sit in the data map, direct or indirect
// - 8-bit ALU doing add, subtract, shifts and logic
// - arithmetic is two's complement
// - two-operand ops use accumulator plus file register or literal
// - single-operand ops work on accumulator or file register
// - accumulator is 8 bits and has no data address
// - ALU updates carry, half carry and zero in status as the op demands
// - subtraction reports borrow in carry and digit borrow in half carry
// - 13-bit counter, low byte writable, high bits from latch, cleared by reset
`ifndef RISC_CORE_DEFS_SVH
`define RISC_CORE_DEFS_SVH

// ****************************************************************
// widths and sizes
// ****************************************************************
`define IW              14
`define DW              8
`define PCW             13
`define PROG_WORDS_512  512
`define PROG_WORDS_1K   1024
`define PROG_WORDS_2K   2048
`define PROG_WORDS      `PROG_WORDS_2K
`define PROG_AW         11
`define DATA_AW         7

// ****************************************************************
// timing: one instruction cycle is four clocks
// ****************************************************************
`define CLK_PERIOD_NS   10
`define CLKS_PER_INSTR  4
`define INSTR_CYCLE_NS  (`CLKS_PER_INSTR * `CLK_PERIOD_NS)

// ****************************************************************
// instruction fields
// ****************************************************************
`define CLS_HI          13
`define CLS_LO          12
`define OP_HI           11
`define OP_LO           8
`define DEST_BIT        7
`define FILE_HI         6
`define LIT_HI          7
`define GOTO_HI         10
`define CLS_FILE        2'h0
`define CLS_NOP         2'h1
`define CLS_GOTO        2'h2
`define CLS_LIT         2'h3
`define NOP_WORD        14'h1000

// ****************************************************************
// opcodes, shared by file and literal classes
// ****************************************************************
`define OP_MOV          4'h0
`define OP_ADD          4'h1
`define OP_SUB          4'h2
`define OP_AND          4'h3
`define OP_IOR          4'h4
`define OP_XOR          4'h5
`define OP_COM          4'h6
`define OP_INC          4'h7
`define OP_DEC          4'h8
`define OP_RLF          4'h9
`define OP_RRF          4'hA
`define OP_SWAP         4'hB
`define OP_CLR          4'hC
`define OP_MOVWF        4'hD

// ****************************************************************
// special registers in the data map
// ****************************************************************
`define SFR_INDIRECT    7'h00
`define SFR_PCL         7'h02
`define SFR_STATUS      7'h03
`define SFR_FSR         7'h04
`define SFR_PROGRAM_COUNTER_HIGH_LATCH      7'h0A

// ****************************************************************
// status bits and reset values
// ****************************************************************
`define ST_C            0
`define ST_DC           1
`define ST_Z            2
`define RST_PC          13'h0000
`define RST_BYTE        8'h00
`define RST_LATCH       5'h00

`endif

// *** risc_core_pkg.sv ***
/*
 * Types shared by the core and its users: phase enum, bus structs, ALU result.
 * Assumes risc_core_defs.svh is on the include path.
 */
`include "risc_core_defs.svh"

package risc_core_pkg;

  typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_t;

  typedef struct packed {
    logic [`DATA_AW-1:0] addr;
    logic [`DW-1:0]      wrData;
    logic                wrEn;
  } data_bus_t;

  typedef struct packed {
    logic                en;
    logic [`PROG_AW-1:0] addr;
    logic [`IW-1:0]      data;
  } prog_load_t;

  // flags and affect are ordered {z, dc, c} like the status low bits
  typedef struct packed {
    logic [`DW-1:0] value;
    logic [2:0]     flags;
    logic [2:0]     affect;
  } alu_res_t;

endpackage : risc_core_pkg

// *** sync_memory.sv ***
/*
 * Single-port-write, single-port-read memory with registered read data.
 * Assumes one clock; contents are undefined until written.
 */
`timescale 1ns/1ps

module sync_memory #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2048,
  parameter int AW    = 11
) (
  // clock
  input  wire logic             clk,
  // write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read port
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    rdData <= mem[rdAddr];
  end

endmodule : sync_memory

// *** risc_core_alu_datapath.sv ***
/*
 * Core datapath: fetch/execute pipeline, internal program memory, 8-bit ALU,
 * accumulator, status, indirect pointer and program counter with its latch.
 * Assumes an external data register file on the data bus that answers a read
 * within two clocks of the address changing; program memory is loaded through
 * the load port before the program is expected to make sense.
 */
`timescale 1ns/1ps
`include "risc_core_defs.svh"

module risc_core_alu_datapath (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // program memory load
  input  wire risc_core_pkg::prog_load_t progLoad,
  // data register file
  input  wire logic [`DW-1:0]          dataRdData,
  output risc_core_pkg::data_bus_t     dataBus,
  // observation
  output logic      [`DW-1:0]          workValue,
  output logic      [`DW-1:0]          statusValue,
  output logic      [`PCW-1:0]         pcValue,
  output logic                         retirePulse
);
  import risc_core_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  phase_t           phaseReg;
  logic [`IW-1:0]   irReg;
  logic             irValidReg;
  logic [`PCW-1:0]  pcReg;
  logic [4:0]       pcLatchReg;
  logic [`DW-1:0]   accReg;
  logic [`DW-1:0]   statusReg;
  logic [`DW-1:0]   statusNext;
  logic [`DW-1:0]   fsrReg;
  logic [`DW-1:0]   operandReg;
  data_bus_t        dataBusReg;
  logic             retireReg;
  logic [`IW-1:0]   progRdData;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [1:0]          cls;
  logic [3:0]          op;
  logic [`DATA_AW-1:0] fileAddr;
  logic [`DATA_AW-1:0] effAddr;
  logic                isFile;
  logic                isLit;
  logic                isGoto;
  logic                writesFile;
  logic                writesAcc;
  logic                isSfr;
  logic                pclWrite;
  logic                branch;
  logic [`DW-1:0]      fileValue;
  alu_res_t            alu;

  assign cls        = irReg[`CLS_HI:`CLS_LO];
  assign op         = irReg[`OP_HI:`OP_LO];
  assign fileAddr   = irReg[`FILE_HI:0];
  // address zero redirects through the pointer register
  assign effAddr    = (fileAddr == `SFR_INDIRECT) ? fsrReg[`DATA_AW-1:0] : fileAddr;
  assign isFile     = irValidReg && (cls == `CLS_FILE);
  assign isLit      = irValidReg && (cls == `CLS_LIT);
  assign isGoto     = irValidReg && (cls == `CLS_GOTO);
  assign writesFile = isFile && (irReg[`DEST_BIT] || (op == `OP_MOVWF));
  assign writesAcc  = isLit || (isFile && !irReg[`DEST_BIT] && (op != `OP_MOVWF));
  assign isSfr      = (effAddr == `SFR_INDIRECT) || (effAddr == `SFR_PCL) || (effAddr == `SFR_STATUS)
                      || (effAddr == `SFR_FSR) || (effAddr == `SFR_PROGRAM_COUNTER_HIGH_LATCH);
  assign pclWrite   = writesFile && (effAddr == `SFR_PCL);
  assign branch     = isGoto || pclWrite;

  // accumulator is never selected here: it has no data address
  always_comb begin
    fileValue = dataRdData;
    if (effAddr == `SFR_INDIRECT) begin
      fileValue = `RST_BYTE;
    end else if (effAddr == `SFR_PCL) begin
      fileValue = pcReg[7:0];
    end else if (effAddr == `SFR_STATUS) begin
      fileValue = statusReg;
    end else if (effAddr == `SFR_FSR) begin
      fileValue = fsrReg;
    end else if (effAddr == `SFR_PROGRAM_COUNTER_HIGH_LATCH) begin
      fileValue = {3'h0, pcLatchReg};
    end
  end

  // ****************************************************************
  // ALU
  // ****************************************************************
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    sum        = 9'h000;
    nib        = 5'h00;
    alu.value  = operandReg;
    alu.flags  = 3'h0;
    alu.affect = 3'b100;
    case (op)
      `OP_MOV:   alu.value = operandReg;
      `OP_ADD: begin
        sum        = {1'b0, operandReg} + {1'b0, accReg};
        nib        = {1'b0, operandReg[3:0]} + {1'b0, accReg[3:0]};
        alu.value  = sum[7:0];
        alu.flags[0] = sum[8];
        alu.flags[1] = nib[4];
        alu.affect = 3'b111;
      end
      `OP_SUB: begin
        // operand minus accumulator; carry out high means no borrow
        sum        = {1'b0, operandReg} + {1'b0, ~accReg} + 9'h001;
        nib        = {1'b0, operandReg[3:0]} + {1'b0, ~accReg[3:0]} + 5'h01;
        alu.value  = sum[7:0];
        alu.flags[0] = sum[8];
        alu.flags[1] = nib[4];
        alu.affect = 3'b111;
      end
      `OP_AND:   alu.value = operandReg & accReg;
      `OP_IOR:   alu.value = operandReg | accReg;
      `OP_XOR:   alu.value = operandReg ^ accReg;
      `OP_COM:   alu.value = ~operandReg;
      `OP_INC:   alu.value = operandReg + 8'h01;
      `OP_DEC:   alu.value = operandReg - 8'h01;
      `OP_RLF: begin
        alu.value    = {operandReg[6:0], statusReg[`ST_C]};
        alu.flags[0] = operandReg[7];
        alu.affect   = 3'b001;
      end
      `OP_RRF: begin
        alu.value    = {statusReg[`ST_C], operandReg[7:1]};
        alu.flags[0] = operandReg[0];
        alu.affect   = 3'b001;
      end
      `OP_SWAP: begin
        alu.value  = {operandReg[3:0], operandReg[7:4]};
        alu.affect = 3'b000;
      end
      `OP_CLR:   alu.value = `RST_BYTE;
      `OP_MOVWF: begin
        alu.value  = accReg;
        alu.affect = 3'b000;
      end
      default:   alu.value = operandReg;
    endcase
    // literal move leaves the flags alone
    if (isLit && (op == `OP_MOV)) begin
      alu.affect = 3'b000;
    end
    alu.flags[2] = (alu.value == `RST_BYTE);
  end

  // ****************************************************************
  // program memory
  // ****************************************************************
  sync_memory #(
    .WIDTH (`IW),
    .DEPTH (`PROG_WORDS),
    .AW    (`PROG_AW)
  ) progMem (
    .clk    (clk),
    .wrEn   (progLoad.en),
    .wrAddr (progLoad.addr),
    .wrData (progLoad.data),
    .rdAddr (pcReg[`PROG_AW-1:0]),
    .rdData (progRdData)
  );

  // ****************************************************************
  // phase sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseReg <= Q1;
    end else begin
      case (phaseReg)
        Q1:      phaseReg <= Q2;
        Q2:      phaseReg <= Q3;
        Q3:      phaseReg <= Q4;
        default: phaseReg <= Q1;
      endcase
    end
  end

  // ****************************************************************
  // data bus and operand capture
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataBusReg <= '0;
    end else begin
      if (phaseReg == Q1) begin
        dataBusReg.addr <= effAddr;
      end
      if (phaseReg == Q4) begin
        dataBusReg.wrData <= alu.value;
      end
      // one-clock strobe; address still holds during it
      dataBusReg.wrEn <= (phaseReg == Q4) && writesFile && !isSfr;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      operandReg <= `RST_BYTE;
    end else if (phaseReg == Q3) begin
      operandReg <= isLit ? irReg[`LIT_HI:0] : fileValue;
    end
  end

  // ****************************************************************
  // write back: accumulator and special registers
  // ****************************************************************
  always_comb begin
    statusNext = statusReg;
    if (writesFile && (effAddr == `SFR_STATUS)) begin
      statusNext = alu.value;
    end
    // flag results win over a plain write of status
    for (int i = 0; i < 3; i++) begin
      if (alu.affect[i] && (isFile || isLit)) begin
        statusNext[i] = alu.flags[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accReg     <= `RST_BYTE;
      statusReg  <= `RST_BYTE;
      fsrReg     <= `RST_BYTE;
      pcLatchReg <= `RST_LATCH;
    end else if (phaseReg == Q4) begin
      if (writesAcc) begin
        accReg <= alu.value;
      end
      statusReg <= statusNext;
      if (writesFile && (effAddr == `SFR_FSR)) begin
        fsrReg <= alu.value;
      end
      if (writesFile && (effAddr == `SFR_PROGRAM_COUNTER_HIGH_LATCH)) begin
        pcLatchReg <= alu.value[4:0];
      end
    end
  end

  // ****************************************************************
  // fetch and program counter
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pcReg      <= `RST_PC;
      irReg      <= `NOP_WORD;
      irValidReg <= 1'b0;
      retireReg  <= 1'b0;
    end else begin
      retireReg <= (phaseReg == Q4) && irValidReg;
      if (phaseReg == Q4) begin
        // the word fetched under a branch is dropped: that is the extra cycle
        irReg      <= progRdData;
        irValidReg <= !branch;
        if (isGoto) begin
          pcReg <= {pcLatchReg[4:3], irReg[`GOTO_HI:0]};
        end else if (pclWrite) begin
          pcReg <= {pcLatchReg, alu.value};
        end else begin
          pcReg <= pcReg + 13'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign dataBus     = dataBusReg;
  assign workValue   = accReg;
  assign statusValue = statusReg;
  assign pcValue     = pcReg;
  assign retirePulse = retireReg;

endmodule : risc_core_alu_datapath

// *** risc_core_alu_datapath_properties.sv ***
/*
 * Port-level timing checks of the core datapath.
 * Assumes it is bound onto risc_core_alu_datapath, one clock, reset arst_n.
 */
`timescale 1ns/1ps
`include "risc_core_defs.svh"

module risc_core_alu_datapath_properties (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       arst_n,
  // program load and data file
  input wire risc_core_pkg::prog_load_t  progLoad,
  input wire logic [`DW-1:0]             dataRdData,
  input wire risc_core_pkg::data_bus_t   dataBus,
  // observation
  input wire logic [`DW-1:0]             workValue,
  input wire logic [`DW-1:0]             statusValue,
  input wire logic [`PCW-1:0]            pcValue,
  input wire logic                       retirePulse
);
  import risc_core_pkg::*;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_retire_once: assert property (retirePulse |=> !retirePulse[*3])
    else $error("retire pulse repeated inside one instruction cycle");
  a_pc_hold: assert property ($changed(pcValue) |=> $stable(pcValue)[*3])
    else $error("fetch address moved inside one instruction cycle");
  a_addr_hold: assert property ($changed(dataBus.addr) |=> $stable(dataBus.addr)[*3])
    else $error("data address moved inside one instruction cycle");
  a_wren_pulse: assert property (dataBus.wrEn |=> !dataBus.wrEn)
    else $error("data write strobe longer than one clock");
  a_wren_retired: assert property (dataBus.wrEn |-> retirePulse)
    else $error("data write without a retired instruction");
  a_wren_addr: assert property (dataBus.wrEn |-> $past(dataBus.addr, 3) == dataBus.addr)
    else $error("data address not held through the write");
  a_no_special: assert property (dataBus.wrEn |-> !(dataBus.addr inside {`SFR_INDIRECT, `SFR_PCL,
    `SFR_STATUS, `SFR_FSR, `SFR_PROGRAM_COUNTER_HIGH_LATCH}))
    else $error("special register write leaked to data bus");
  a_work_retire: assert property ($changed(workValue) |-> retirePulse)
    else $error("accumulator changed outside retirement");
  a_status_retire: assert property ($changed(statusValue) |-> retirePulse)
    else $error("status changed outside retirement");

endmodule : risc_core_alu_datapath_properties

bind risc_core_alu_datapath risc_core_alu_datapath_properties u_props (
  .clk         (clk),
  .arst_n      (arst_n),
  .progLoad    (progLoad),
  .dataRdData  (dataRdData),
  .dataBus     (dataBus),
  .workValue   (workValue),
  .statusValue (statusValue),
  .pcValue     (pcValue),
  .retirePulse (retirePulse)
);

// *** data_file_model.sv ***
/*
 * Behavioural data register file on the far side of the data bus.
 * Assumes combinational read and a write on each clock with wrEn high.
 */
`timescale 1ns/1ps
`include "risc_core_defs.svh"

module data_file_model (
  // clock
  input wire logic                     clk,
  // data bus
  input wire risc_core_pkg::data_bus_t dataBus,
  output logic [`DW-1:0]               dataRdData
);
  import risc_core_pkg::*;

  logic [`DW-1:0] mem [0:127];

  // cleared so that an unwritten read is never unknown
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'h00;
  end

  // own bus, own storage: reads overlap program fetch
  assign dataRdData = mem[dataBus.addr];

  // plain always: the array is also cleared by the initial block above
  always @(posedge clk) begin
    if (dataBus.wrEn) mem[dataBus.addr] <= dataBus.wrData;
  end

endmodule : data_file_model

// *** testbench.sv ***
/*
 * Self-checking bench: runs a small program and checks results per instruction.
 * Assumes the datapath, its package and the data file model are compiled first.
 */
`timescale 1ns/1ps
`include "risc_core_defs.svh"

module testbench;
  import risc_core_pkg::*;

  logic            clk;
  logic            arst_n;
  prog_load_t      progLoad;
  logic [7:0]      dataRdData;
  data_bus_t       dataBus;
  logic [7:0]      workValue;
  logic [7:0]      statusValue;
  logic [12:0]     pcValue;
  logic            retirePulse;
  int              miscompares;
  int              nChecks;
  int              cycles = 0;
  logic [13:0]     prog [0:21] = '{14'h300F, 14'h3101, 14'h0D20, 14'h3210, 14'h3001, 14'h3200,
                                   14'h0120, 14'h200D, 14'h3055, 14'h3055, 14'h3300, 14'h0002,
                                   14'h200C, 14'h3020, 14'h0D04, 14'h0900, 14'h3001, 14'h0D0A,
                                   14'h30F0, 14'h311D, 14'h0D02, 14'h1000};

  risc_core_alu_datapath dut (
    .clk(clk), .arst_n(arst_n), .progLoad(progLoad), .dataRdData(dataRdData), .dataBus(dataBus),
    .workValue(workValue), .statusValue(statusValue), .pcValue(pcValue), .retirePulse(retirePulse));

  data_file_model partner (.clk(clk), .dataBus(dataBus), .dataRdData(dataRdData));

  // ****************************************************************
  // clock and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  // waits for the next retirement, then checks accumulator, flags and spacing
  task automatic step(input logic [7:0] w, input logic [2:0] f, input int gap);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (retirePulse !== 1'b1 && n < 40);
    cmp(16'(workValue), 16'(w), "accumulator");
    cmp(16'(statusValue[2:0]), 16'(f), "flags");
    if (gap != 0) cmp(16'(n), 16'(gap), "instruction length");
  endtask : step

  // runs beside the first scenario: one word a clock stays ahead of one fetch a cycle
  task automatic load_program();
    for (int i = 0; i < 22; i++) begin
      @(posedge clk);
      #1;
      progLoad = '{1'b1, 11'(i), prog[i]};
    end
    // jump target reached through the latch, and the word fetched behind it
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      #1;
      progLoad = '{1'b1, 11'h10D + 11'(j), (j == 0) ? 14'h200A : `NOP_WORD};
    end
    @(posedge clk);
    #1;
    progLoad.en = 1'b0;
  endtask : load_program

  task automatic run_arith();
    step(8'h0F, 3'b000, 0);
    step(8'h10, 3'b010, 4);
    step(8'h10, 3'b010, 4);
    step(8'h00, 3'b111, 4);
    // the write strobe comes with retirement and the byte is stored a clock later, so look one step later
    cmp(16'(partner.mem[32]), 16'h0010, "stored byte");
    step(8'h01, 3'b111, 4);
    step(8'hFF, 3'b000, 4);
    step(8'h0F, 3'b001, 4);
  endtask : run_arith

  task automatic run_branch();
    step(8'h0F, 3'b001, 4);
    step(8'h20, 3'b001, 8);
    step(8'h20, 3'b001, 4);
    step(8'h21, 3'b000, 4);
    cmp(16'(dataBus.addr), 16'h0020, "effective address");
    step(8'h01, 3'b000, 4);
    step(8'h01, 3'b000, 4);
    step(8'hF0, 3'b000, 4);
    step(8'h0D, 3'b001, 4);
    step(8'h0D, 3'b001, 4);
    cmp(16'(pcValue), 16'h010D, "counter from latch");
    step(8'h0D, 3'b001, 8);
    cmp(16'(pcValue), 16'h000A, "counter after jump");
    step(8'h00, 3'b101, 8);
    step(8'h0C, 3'b001, 4);
    step(8'h0C, 3'b001, 4);
    step(8'h0C, 3'b001, 8);
  endtask : run_branch

  // reset in mid-run clears the counter and restarts at word 0
  task automatic run_reset();
    @(posedge clk);
    #1;
    arst_n = 1'b0;
    #1;
    cmp(16'(pcValue), 16'h0000, "counter in reset");
    cmp(16'(workValue), 16'h0000, "accumulator in reset");
    cmp(16'(dataBus.wrEn), 16'h0000, "write strobe in reset");
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    step(8'h0F, 3'b000, 0);
    step(8'h10, 3'b010, 4);
  endtask : run_reset

  task automatic finish_test();
    if (miscompares == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    arst_n      = 1'b0;
    progLoad    = '0;
    miscompares = 0;
    nChecks     = 0;
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    fork
      load_program();
      run_arith();
    join
    run_branch();
    run_reset();
    finish_test();
  end

endmodule : testbench
